// file: hw/power_park_pkg.sv
// Constants and types for the power, park and debug-strap sequencer
package power_park_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int STRAP_DELAY_NS = 1500;
  localparam int STRAP_CYCLES = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_TIME_US = 100;
  localparam int INIT_CYCLES = (INIT_TIME_US * 1000) / CLK_PERIOD_NS;
  // Fast park must finish well inside the 32 us the supplies are held
  localparam int FAST_PARK_US = 20;
  localparam int FAST_PARK_CYCLES = (FAST_PARK_US * 1000) / CLK_PERIOD_NS;
  localparam int NORMAL_PARK_US = 500;
  localparam int NORMAL_PARK_CYCLES_DEF = (NORMAL_PARK_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ****************************************
  // Strap codes and reset values
  // ****************************************
  localparam logic [3:0] STRAP_NORMAL = 4'h0;
  localparam logic [3:0] STRAP_CLOCK_DEBUG = 4'h5;
  localparam logic [3:0] STRAP_CALIBRATION = 4'h8;
  localparam logic [3:0] STRAP_RESET_VALUE = 4'h0;
  localparam logic [7:0] PROBE_RESET_VALUE = 8'h00;
  localparam int TAP_COUNT = 6;
  localparam int DIV_W = 7;

  typedef enum logic [2:0] {
    ST_HELD,
    ST_INIT,
    ST_RUN,
    ST_NORMAL_PARK,
    ST_FAST_PARK,
    ST_PARKED
  } seq_state_t;

endpackage

// file: hw/probe_clk_if.sv
// Interface carrying the divided debug clock taps
`timescale 1ns/100ps
`default_nettype none
interface probe_clk_if;
  import power_park_pkg::*;
  logic [TAP_COUNT-1:0] taps;
  modport gen (output taps);
  modport use_side (input taps);
endinterface
`default_nettype wire

// file: hw/probe_clock_gen.sv
// Free-running divider producing the internal clock taps for clock debug
`timescale 1ns/100ps
`default_nettype none
module probe_clock_gen
  import power_park_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  probe_clk_if.gen tap_port
);
  // Taps are ratios of the reference, not the fabric clocks themselves
  logic [DIV_W-1:0] div;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tap_port.taps <= '0;
    end else begin
      tap_port.taps <= {div[0], div[3], div[4], div[2], div[1], div[0]};
    end
  end

endmodule
`default_nettype wire

// file: hw/power_park_seq_debug_strap.sv
// Start-up, park sequencing and debug strap capture for the display controller
`timescale 1ns/100ps
`default_nettype none
module power_park_seq_debug_strap
  import power_park_pkg::*;
#(
  parameter int NORMAL_PARK_CYCLES = NORMAL_PARK_CYCLES_DEF
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic controller_reset_n_in,
  input wire logic park_request_n_in,
  input wire logic projection_on_request_in,
  input wire logic [3:0] probe_strap_in,
  input wire logic sel_write_in,
  input wire logic [3:0] sel_value_in,
  input wire logic vsync_in,
  input wire logic wheel_index_dly_in,
  input wire logic seq_index_in,
  input wire logic wheel_spoke_in,
  input wire logic wheel_rev_in,
  input wire logic [2:0] reset_aux_in,
  output logic [7:0] debug_probe_bus_out,
  output logic [7:0] debug_probe_oe_out,
  output logic init_done_out,
  output logic init_done_oe_out,
  output logic park_busy_out,
  output logic park_done_out,
  output logic [3:0] strap_value_out,
  output logic strap_valid_out
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] park_sync;
  logic [1:0] proj_sync;
  logic [1:0] rst_sync;
  logic park_prev;
  logic proj_prev;
  logic rst_prev;
  logic park_rise;
  logic park_fall;
  logic proj_fall;
  logic rst_rise;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // Park idles high, so reset there to avoid a false rise
      park_sync <= 2'b11;
      proj_sync <= 2'b00;
      rst_sync <= 2'b00;
      park_prev <= 1'b1;
      proj_prev <= 1'b0;
      rst_prev <= 1'b0;
    end else begin
      park_sync <= {park_sync[0], park_request_n_in};
      proj_sync <= {proj_sync[0], projection_on_request_in};
      rst_sync <= {rst_sync[0], controller_reset_n_in};
      park_prev <= park_sync[1];
      proj_prev <= proj_sync[1];
      rst_prev <= rst_sync[1];
    end
  end

  assign park_rise = park_sync[1] && !park_prev;
  assign park_fall = !park_sync[1] && park_prev;
  assign proj_fall = !proj_sync[1] && proj_prev;
  assign rst_rise = rst_sync[1] && !rst_prev;

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t state;
  logic [CNT_W-1:0] seq_cnt;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_HELD;
      seq_cnt <= '0;
    end else if (!rst_sync[1]) begin
      state <= ST_HELD;
      seq_cnt <= '0;
    end else begin
      seq_cnt <= seq_cnt + 1'b1;
      unique case (state)
        ST_HELD: begin
          seq_cnt <= '0;
          if (rst_rise) begin
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (seq_cnt == CNT_W'(INIT_CYCLES - 1)) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          seq_cnt <= '0;
          if (park_fall) begin
            state <= ST_FAST_PARK;
          end else if (proj_fall) begin
            state <= ST_NORMAL_PARK;
          end
        end
        ST_NORMAL_PARK: begin
          if (park_fall) begin
            state <= ST_FAST_PARK;
            seq_cnt <= '0;
          end else if (seq_cnt == CNT_W'(NORMAL_PARK_CYCLES - 1)) begin
            state <= ST_PARKED;
          end
        end
        ST_FAST_PARK: begin
          if (seq_cnt == CNT_W'(FAST_PARK_CYCLES - 1)) begin
            state <= ST_PARKED;
          end
        end
        ST_PARKED: begin
          seq_cnt <= '0;
        end
      endcase
    end
  end

  // Done is open drain: pulled low through init, released otherwise
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      init_done_out <= 1'b0;
      init_done_oe_out <= 1'b0;
      park_busy_out <= 1'b0;
      park_done_out <= 1'b0;
    end else begin
      init_done_out <= 1'b0;
      init_done_oe_out <= (state == ST_INIT);
      park_busy_out <= (state == ST_NORMAL_PARK) || (state == ST_FAST_PARK);
      park_done_out <= (state == ST_PARKED);
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  logic sampling;
  logic [CNT_W-1:0] strap_cnt;
  logic [3:0] strap;
  logic strap_valid;
  logic first_cycle;

  // Reset release is noticed one clock late by a flop, never by the reset itself
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sampling <= 1'b0;
      strap_cnt <= '0;
      strap <= STRAP_RESET_VALUE;
      strap_valid <= 1'b0;
    end else if (first_cycle || park_rise) begin
      sampling <= 1'b1;
      strap_cnt <= '0;
      strap_valid <= 1'b0;
    end else if (sampling) begin
      strap_cnt <= strap_cnt + 1'b1;
      if (strap_cnt == CNT_W'(STRAP_CYCLES - 1)) begin
        sampling <= 1'b0;
        strap <= probe_strap_in;
        strap_valid <= 1'b1;
      end
    end
  end

  // ****************************************
  // Probe bus selection and output
  // ****************************************
  logic [3:0] probe_sel;
  logic [7:0] next_probe;
  probe_clk_if taps_if ();

  probe_clock_gen u_clk_gen (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .tap_port(taps_if.gen)
  );

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      probe_sel <= STRAP_RESET_VALUE;
    end else if (sampling && strap_cnt == CNT_W'(STRAP_CYCLES - 1)) begin
      probe_sel <= probe_strap_in;
    end else if (strap_valid && sel_write_in) begin
      probe_sel <= sel_value_in;
    end
  end

  always_comb begin
    next_probe = PROBE_RESET_VALUE;
    if (probe_sel == STRAP_CLOCK_DEBUG) begin
      next_probe = {1'b1, taps_if.taps, 1'b1};
    end else if (probe_sel == STRAP_CALIBRATION) begin
      next_probe = {reset_aux_in, wheel_rev_in, wheel_spoke_in, seq_index_in, wheel_index_dly_in, vsync_in};
    end
  end

  // Low four pins are strap inputs while sampling, so they float then
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      debug_probe_bus_out <= PROBE_RESET_VALUE;
      debug_probe_oe_out <= 8'h00;
      strap_value_out <= STRAP_RESET_VALUE;
      strap_valid_out <= 1'b0;
    end else begin
      debug_probe_bus_out <= next_probe;
      debug_probe_oe_out <= {4'hF, {4{strap_valid}}};
      strap_value_out <= strap;
      strap_valid_out <= strap_valid;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_sample_start;
    sampling && strap_cnt == '0;
  endsequence

  sequence s_reset_release;
    rst_rise && state == ST_HELD;
  endsequence

  property p_strap_delay;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (s_sample_start and !(first_cycle || park_rise)) |-> !strap_valid [*8];
  endproperty
  a_strap_delay: assert property (p_strap_delay) else $error("Strap captured too early");

  property p_strap_select;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(strap_valid) |-> probe_sel == strap;
  endproperty
  a_strap_select: assert property (p_strap_select) else $error("Selection not taken from strap");

  property p_zero_mode;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      probe_sel == STRAP_NORMAL ##1 probe_sel == STRAP_NORMAL |=> debug_probe_bus_out == 8'h00;
  endproperty
  a_zero_mode: assert property (p_zero_mode) else $error("Probe bus toggles in normal mode");

  property p_clock_ends;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      probe_sel == STRAP_CLOCK_DEBUG |=> debug_probe_bus_out[0] && debug_probe_bus_out[7];
  endproperty
  a_clock_ends: assert property (p_clock_ends) else $error("Clock debug end bits not high");

  property p_cal_map;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      probe_sel == STRAP_CALIBRATION |=> debug_probe_bus_out[0] == $past(vsync_in);
  endproperty
  a_cal_map: assert property (p_cal_map) else $error("Calibration bit 0 not vertical sync");

  property p_sw_select;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      strap_valid && sel_write_in && !sampling |=> probe_sel == $past(sel_value_in);
  endproperty
  a_sw_select: assert property (p_sw_select) else $error("Software selection ignored");

  property p_init_start;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      s_reset_release |=> state == ST_INIT ##1 init_done_oe_out;
  endproperty
  a_init_start: assert property (p_init_start) else $error("Init not started on reset release");

  property p_done_after_init;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      state == ST_INIT && seq_cnt == CNT_W'(INIT_CYCLES - 1) && rst_sync[1] |=> ##1 !init_done_oe_out;
  endproperty
  a_done_after_init: assert property (p_done_after_init) else $error("Done not released after init");

  property p_fast_park;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      state == ST_RUN && park_fall && rst_sync[1] |=> state == ST_FAST_PARK ##1 park_busy_out;
  endproperty
  a_fast_park: assert property (p_fast_park) else $error("Fast park not started");

  property p_normal_park;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      state == ST_RUN && proj_fall && !park_fall && rst_sync[1] |=> state == ST_NORMAL_PARK;
  endproperty
  a_normal_park: assert property (p_normal_park) else $error("Normal park not started");

  property p_reset_release;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      !rst_sync[1] |=> ##1 !init_done_oe_out;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("Done line driven under reset");

endmodule
`default_nettype wire

// file: tb/pmic_host_model.sv
// Behavioural host processor and power-management partner of the sequencer
`timescale 1ns/100ps
`default_nettype none
module pmic_host_model (
  input wire logic ref_clk_in,
  input wire logic init_done_in,
  input wire logic init_done_oe_in,
  input wire logic park_done_in,
  input wire logic [3:0] probe_in,
  input wire logic [3:0] probe_oe_in,
  output logic controller_reset_n_out,
  output logic park_request_n_out,
  output logic projection_on_request_out,
  output logic [3:0] strap_level_out,
  output logic done_line_out
);
  logic [3:0] jumper;
  logic host_may_talk;
  int since_park;
  // Board pull-up on the open-drain done line
  assign done_line_out = init_done_oe_in ? init_done_in : 1'b1;
  // Pulldowns give 0000 unless a jumper pulls a pin up
  assign strap_level_out = (probe_oe_in & probe_in) | (~probe_oe_in & jumper);
  always @(posedge ref_clk_in) begin
    since_park <= park_request_n_out ? 0 : since_park + 1;
  end
  initial begin
    jumper = 4'h0;
    host_may_talk = 1'b0;
    controller_reset_n_out = 1'b0;
    park_request_n_out = 1'b0;
    projection_on_request_out = 1'b0;
  end
  task automatic power_up();
    @(negedge ref_clk_in);
    park_request_n_out = 1'b1;
    projection_on_request_out = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    controller_reset_n_out = 1'b1;
  endtask
  // Cycles from reset release until the done line floats high
  task automatic host_wait_ready(output int n);
    n = 0;
    while (done_line_out !== 1'b0 && n < 20) begin
      @(negedge ref_clk_in);
      n++;
    end
    while (done_line_out !== 1'b1 && n < 5000) begin
      @(negedge ref_clk_in);
      n++;
    end
    host_may_talk = (done_line_out === 1'b1);
  endtask
  task automatic projection_off();
    @(negedge ref_clk_in);
    host_may_talk = 1'b0;
    projection_on_request_out = 1'b0;
  endtask
  task automatic park_set(input logic v);
    @(negedge ref_clk_in);
    park_request_n_out = v;
  endtask
  // Reset after parking or a 3000-cycle timeout, and never inside the fast-park hold time
  task automatic shutdown();
    for (int i = 0; i < 3000; i++) begin
      if (park_done_in === 1'b1 && (park_request_n_out || since_park > 1280)) break;
      @(negedge ref_clk_in);
    end
    controller_reset_n_out = 1'b0;
    host_may_talk = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench of the power, park and debug-strap sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import power_park_pkg::*;
  localparam int NPARK = 50;
  logic ref_clk_in, sys_rst_in, ctl_rst_n, park_n, projection_on_request, sel_write, valid;
  logic vsync, wheel_idx, seq_idx, spoke, rev, done_d, done_oe, busy, pdone, done_line;
  logic [3:0] strap_lvl, sel_value, strap;
  logic [2:0] aux;
  logic [7:0] bus, oe, prev, acc;
  int n_mismatch, n_tests, n;

  power_park_seq_debug_strap #(.NORMAL_PARK_CYCLES(NPARK)) u_dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .controller_reset_n_in(ctl_rst_n),
    .park_request_n_in(park_n), .projection_on_request_in(projection_on_request), .probe_strap_in(strap_lvl),
    .sel_write_in(sel_write), .sel_value_in(sel_value), .vsync_in(vsync),
    .wheel_index_dly_in(wheel_idx), .seq_index_in(seq_idx), .wheel_spoke_in(spoke),
    .wheel_rev_in(rev), .reset_aux_in(aux), .debug_probe_bus_out(bus), .debug_probe_oe_out(oe),
    .init_done_out(done_d), .init_done_oe_out(done_oe), .park_busy_out(busy),
    .park_done_out(pdone), .strap_value_out(strap), .strap_valid_out(valid));

  pmic_host_model u_partner (
    .ref_clk_in(ref_clk_in), .init_done_in(done_d), .init_done_oe_in(done_oe),
    .park_done_in(pdone), .probe_in(bus[3:0]), .probe_oe_in(oe[3:0]),
    .controller_reset_n_out(ctl_rst_n), .park_request_n_out(park_n),
    .projection_on_request_out(projection_on_request), .strap_level_out(strap_lvl), .done_line_out(done_line));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_bit(ref logic s, input int limit, output int cnt);
    cnt = 0;
    while (s !== 1'b1 && cnt < limit) begin
      @(negedge ref_clk_in);
      cnt++;
    end
  endtask
  task automatic set_sel(input logic [3:0] v);
    @(negedge ref_clk_in);
    sel_write = 1'b1;
    sel_value = v;
    @(negedge ref_clk_in);
    sel_write = 1'b0;
    repeat (2) @(negedge ref_clk_in);
  endtask
  // Drive calibration sources, then see them on the probe bus in order
  task automatic cal_check(input logic [7:0] p);
    @(negedge ref_clk_in);
    {aux, rev, spoke, seq_idx, wheel_idx, vsync} = p;
    repeat (3) @(negedge ref_clk_in);
    check(bus, p);
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk_in);
    n_mismatch++;
    $display("MISMATCH t=%0t seen=%h expected=%h", $time, 8'h00, 8'h01);
    complete_run();
  end

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    {sel_write, sel_value, vsync, wheel_idx, seq_idx, spoke, rev, aux} = '0;
    sys_rst_in = 1'b1;
    repeat (12) @(negedge ref_clk_in);
    // Set after the partner's own start-up values
    u_partner.jumper = 4'h5;
    check(valid, 1'b0);
    sys_rst_in = 1'b0;
    wait_bit(valid, 200, n);
    check(n >= STRAP_CYCLES - 1 && n <= STRAP_CYCLES + 3, 1'b1);
    check(strap, STRAP_CLOCK_DEBUG);
    check(oe, 8'hff);
    repeat (2) @(negedge ref_clk_in);
    // Slowest tap may need a long window before it toggles
    acc = 8'h00;
    prev = bus;
    repeat (300) begin
      @(negedge ref_clk_in);
      acc |= prev ^ bus;
      prev = bus;
    end
    check(bus & 8'h81, 8'h81);
    check(acc, 8'h7e);
    u_partner.power_up();
    u_partner.host_wait_ready(n);
    check(n >= INIT_CYCLES && n <= INIT_CYCLES + 10, 1'b1);
    set_sel(STRAP_CALIBRATION);
    cal_check(8'ha5);
    cal_check(8'h5a);
    set_sel(STRAP_NORMAL);
    acc = 8'h00;
    repeat (50) begin
      @(negedge ref_clk_in);
      acc |= bus;
    end
    check(acc, 8'h00);
    check(strap, STRAP_CLOCK_DEBUG);
    u_partner.projection_off();
    wait_bit(busy, 10, n);
    check(busy, 1'b1);
    wait_bit(pdone, NPARK + 20, n);
    check(n >= NPARK - 6 && n <= NPARK + 4, 1'b1);
    u_partner.shutdown();
    repeat (5) @(negedge ref_clk_in);
    check(done_line, 1'b1);
    check(pdone, 1'b0);
    u_partner.power_up();
    u_partner.host_wait_ready(n);
    check(done_line, 1'b1);
    u_partner.park_set(1'b0);
    wait_bit(busy, 10, n);
    check(busy, 1'b1);
    wait_bit(pdone, FAST_PARK_CYCLES + 20, n);
    check(n >= FAST_PARK_CYCLES - 6 && n <= FAST_PARK_CYCLES + 4, 1'b1);
    u_partner.shutdown();
    u_partner.jumper = 4'h8;
    u_partner.park_set(1'b1);
    repeat (8) @(negedge ref_clk_in);
    check(oe, 8'hf0);
    set_sel(STRAP_NORMAL);
    repeat (STRAP_CYCLES + 10) @(negedge ref_clk_in);
    check(valid, 1'b1);
    check(strap, STRAP_CALIBRATION);
    cal_check(8'h3c);
    complete_run();
  end
endmodule
`default_nettype wire
